// file: quad_pot_pkg.sv
// Purpose: shared constants and types for the quad pot serial decoder
// Assumes: one system clock; serial pins already synchronous to it
// Notes:   frame bit counts are counted in serial clock rising edges
package quad_pot_pkg;
   localparam int          POTS           = 4;
   localparam int          SETTINGS       = 4;
   localparam int          WIPER_BITS     = 6;
   localparam int          MEM_WORDS      = POTS * SETTINGS;

   localparam logic [3:0]  DEVICE_TYPE    = 4'h5;
   localparam logic [1:0]  ADDR_PAD       = 2'h0;

   localparam logic [3:0]  OP_RD_WIPER    = 4'h9;
   localparam logic [3:0]  OP_WR_WIPER    = 4'ha;
   localparam logic [3:0]  OP_RD_SETTING  = 4'hb;
   localparam logic [3:0]  OP_WR_SETTING  = 4'hc;
   localparam logic [3:0]  OP_RECALL      = 4'hd;
   localparam logic [3:0]  OP_SAVE        = 4'he;
   localparam logic [3:0]  OP_G_RECALL    = 4'h1;
   localparam logic [3:0]  OP_G_SAVE      = 4'h8;
   localparam logic [3:0]  OP_INCDEC      = 4'h2;
   localparam logic [3:0]  OP_STATUS      = 4'h5;
   localparam logic [3:0]  STATUS_SELECT  = 4'h1;

   localparam logic [5:0]  CNT_HDR_LAST   = 6'd7;
   localparam logic [5:0]  CNT_INSTR_LAST = 6'd15;
   localparam logic [5:0]  CNT_DATA_LAST  = 6'd23;
   localparam logic [5:0]  CNT_TWO_BYTE   = 6'd16;
   localparam logic [5:0]  CNT_THREE_BYTE = 6'd24;
   localparam logic [5:0]  CNT_MAX        = 6'h3f;

   localparam logic [5:0]  WIPER_MAX      = 6'h3f;
   localparam logic [5:0]  WIPER_MIN      = 6'h00;
   localparam logic [5:0]  WIPER_RESET    = 6'h00;
   localparam logic [1:0]  POT_FIRST      = 2'h0;
   localparam logic [1:0]  POT_LAST       = 2'h3;

   // nonvolatile write time and its cycle count, least time rounded up
   localparam int          CLOCK_PERIOD_PS = 5000;
   localparam int          WRITE_TIME_US   = 10;
   localparam int          WRITE_CYCLES    =
      (WRITE_TIME_US * 1000000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
   localparam int          TIMER_BITS      = 32;

   typedef struct packed {
      logic [3:0] opcode;
      logic [1:0] setting;
      logic [1:0] pot;
   } instr_t;

   typedef struct packed {
      logic       en;
      logic [3:0] addr;
      logic [5:0] data;
   } mem_wr_t;

   typedef enum logic [1:0] {
      seq_idle,
      seq_read,
      seq_apply,
      seq_save
   } seq_state_t;
endpackage

// file: setting_store.sv
// Purpose: stored-setting memory, one word per pot and setting
// Assumes: one write port, one read port with registered read data
// Notes:   address is {setting, pot}
`timescale 1ns/1ps
module setting_store
   import quad_pot_pkg::*;
#(
   parameter int WORDS = MEM_WORDS,
   parameter int WIDTH = WIPER_BITS
)
(
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire mem_wr_t          wr,
   input  wire logic [3:0]       rd_addr,
   output logic      [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] store [WORDS];

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < WORDS; i++)
         begin
            store[i] <= '0;
         end
         rd_data <= '0;
      end
      else
      begin
         if (wr.en)
         begin
            store[wr.addr] <= wr.data;
         end
         rd_data <= store[rd_addr];
      end
   end
endmodule

// file: quad_pot_spi_instruction_decoder.sv
// Purpose: serial instruction decoder for four digital pots
// Assumes: serial clock high and low phases each last three clocks or more
// Notes:   input sampled on serial clock rise, output changes on its fall
`timescale 1ns/1ps
module quad_pot_spi_instruction_decoder
   import quad_pot_pkg::*;
#(
   parameter int write_cycles = WRITE_CYCLES
)
(
   input  wire logic                          clock,
   input  wire logic                          nrst,
   input  wire logic                          cs_n,
   input  wire logic                          sck,
   input  wire logic                          si,
   output logic                               so,
   output logic                               so_en,
   input  wire logic                          chip_addr_hi,
   input  wire logic                          chip_addr_lo,
   output logic [POTS-1:0][WIPER_BITS-1:0]    wiper_position_reg,
   output logic                               write_in_progress
);
   logic                  sck_q;
   logic                  cs_q;
   logic [5:0]            bit_count;
   logic [7:0]            shift;
   logic                  hdr_ok;
   instr_t                instr;
   logic [7:0]            data_byte;
   logic [7:0]            out_shift;
   logic [TIMER_BITS-1:0] wip_timer;
   seq_state_t            seq_state;
   logic [1:0]            seq_pot;
   logic [1:0]            seq_last;
   logic [1:0]            seq_set;
   logic [5:0]            mem_rdata;

   // one step toward either end, holding at the ends
   function automatic logic [5:0] step(input logic [5:0] cur, input logic up);
      logic [5:0] res;
      res = cur;
      if (up && cur != WIPER_MAX)
      begin
         res = cur + 6'h01;
      end
      else if (!up && cur != WIPER_MIN)
      begin
         res = cur - 6'h01;
      end
      return res;
   endfunction

   // instructions whose third byte is driven by the device
   function automatic logic is_read(input instr_t ins);
      return ins.opcode == OP_RD_WIPER || ins.opcode == OP_RD_SETTING
         || (ins.opcode == OP_STATUS && {ins.setting, ins.pot} == STATUS_SELECT);
   endfunction

   wire        sck_rise  = sck & ~sck_q & ~cs_n;
   wire        sck_fall  = ~sck & sck_q & ~cs_n;
   wire        cs_rise   = cs_n & ~cs_q;
   wire [7:0]  next_shift = {shift[6:0], si};
   wire [7:0]  hdr_expect = {DEVICE_TYPE, ADDR_PAD, chip_addr_hi, chip_addr_lo};
   wire        busy      = (wip_timer != '0) || (seq_state != seq_idle);
   wire        end_two   = cs_rise && hdr_ok && bit_count == CNT_TWO_BYTE;
   wire        end_three = cs_rise && hdr_ok && bit_count == CNT_THREE_BYTE;
   wire        pots_zero = instr.pot == POT_FIRST;

   wire do_wr_wiper = end_three && instr.opcode == OP_WR_WIPER;
   wire do_wr_setting = end_three && instr.opcode == OP_WR_SETTING && !busy;
   wire do_recall = end_two && instr.opcode == OP_RECALL && !busy;
   wire do_save   = end_two && instr.opcode == OP_SAVE && !busy;
   wire do_grecall = end_two && instr.opcode == OP_G_RECALL && pots_zero
                     && !busy;
   wire do_gsave  = end_two && instr.opcode == OP_G_SAVE && pots_zero
                    && !busy;
   wire step_ev   = sck_rise && hdr_ok && instr.opcode == OP_INCDEC
                    && bit_count >= CNT_TWO_BYTE;
   wire seq_done_save = seq_state == seq_save && seq_pot == seq_last;
   wire wip_start = do_wr_setting || do_save || seq_done_save;

   wire [3:0] rd_addr = (seq_state != seq_idle) ? {seq_set, seq_pot}
                                                : {instr.setting, instr.pot};

   mem_wr_t mem_wr;
   always_comb
   begin
      mem_wr = '0;
      if (seq_state == seq_save)
      begin
         mem_wr = '{en: 1'b1, addr: {seq_set, seq_pot},
                    data: wiper_position_reg[seq_pot]};
      end
      else if (do_wr_setting)
      begin
         mem_wr = '{en: 1'b1, addr: {instr.setting, instr.pot},
                    data: data_byte[WIPER_BITS-1:0]};
      end
      else if (do_save)
      begin
         mem_wr = '{en: 1'b1, addr: {instr.setting, instr.pot},
                    data: wiper_position_reg[instr.pot]};
      end
   end

   setting_store u_store (
      .clock   (clock),
      .nrst    (nrst),
      .wr      (mem_wr),
      .rd_addr (rd_addr),
      .rd_data (mem_rdata)
   );

   // one shared wiper write port
   logic [POTS-1:0] wiper_we;
   logic [5:0]      wiper_wdata;
   always_comb
   begin
      wiper_we    = '0;
      wiper_wdata = mem_rdata;
      if (seq_state == seq_apply)
      begin
         wiper_we[seq_pot] = 1'b1;
      end
      else if (do_wr_wiper)
      begin
         wiper_we[instr.pot] = 1'b1;
         wiper_wdata         = data_byte[WIPER_BITS-1:0];
      end
      else if (step_ev)
      begin
         wiper_we[instr.pot] = 1'b1;
         wiper_wdata         = step(wiper_position_reg[instr.pot], si);
      end
   end

   genvar g;
   generate
      for (g = 0; g < POTS; g++)
      begin : g_wiper
         always_ff @(posedge clock or negedge nrst)
         begin
            if (!nrst)
            begin
               wiper_position_reg[g] <= WIPER_RESET;
            end
            else if (wiper_we[g])
            begin
               wiper_position_reg[g] <= wiper_wdata;
            end
         end
      end
   endgenerate

   // serial frame capture
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         sck_q     <= 1'b0;
         cs_q      <= 1'b1;
         bit_count <= '0;
         shift     <= '0;
         hdr_ok    <= 1'b0;
         instr     <= '0;
         data_byte <= '0;
      end
      else
      begin
         sck_q <= sck;
         cs_q  <= cs_n;
         if (cs_n)
         begin
            bit_count <= '0;
            hdr_ok    <= 1'b0;
         end
         else if (sck_rise)
         begin
            shift <= next_shift;
            if (bit_count != CNT_MAX)
            begin
               bit_count <= bit_count + 6'h01;
            end
            if (bit_count == CNT_HDR_LAST)
            begin
               hdr_ok <= next_shift[7:0] == hdr_expect;
            end
            if (bit_count == CNT_INSTR_LAST)
            begin
               instr <= instr_t'(next_shift[7:0]);
            end
            if (bit_count == CNT_DATA_LAST)
            begin
               data_byte <= next_shift[7:0];
            end
         end
      end
   end

   // serial output byte
   logic [7:0] out_byte;
   always_comb
   begin
      out_byte = '0;
      case (instr.opcode)
         OP_RD_WIPER:   out_byte = {2'b00, wiper_position_reg[instr.pot]};
         OP_RD_SETTING: out_byte = {2'b00, mem_rdata};
         OP_STATUS:     out_byte = {7'b0000000, write_in_progress};
         default:       out_byte = '0;
      endcase
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         out_shift <= '0;
         so_en     <= 1'b0;
      end
      else if (cs_n)
      begin
         so_en <= 1'b0;
      end
      else if (sck_fall)
      begin
         if (bit_count == CNT_TWO_BYTE && hdr_ok && is_read(instr))
         begin
            out_shift <= out_byte;
            so_en     <= 1'b1;
         end
         else
         begin
            out_shift <= {out_shift[6:0], 1'b0};
         end
      end
   end

   assign so = out_shift[7];

   // transfer sequencer, two cycles per recalled pot, one per saved pot
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         seq_state <= seq_idle;
         seq_pot   <= '0;
         seq_last  <= '0;
         seq_set   <= '0;
      end
      else
      begin
         case (seq_state)
            seq_idle:
            begin
               seq_set <= instr.setting;
               if (do_recall)
               begin
                  seq_pot   <= instr.pot;
                  seq_last  <= instr.pot;
                  seq_state <= seq_read;
               end
               else if (do_grecall)
               begin
                  seq_pot   <= POT_FIRST;
                  seq_last  <= POT_LAST;
                  seq_state <= seq_read;
               end
               else if (do_gsave)
               begin
                  seq_pot   <= POT_FIRST;
                  seq_last  <= POT_LAST;
                  seq_state <= seq_save;
               end
            end
            seq_read:
            begin
               seq_state <= seq_apply;
            end
            seq_apply:
            begin
               seq_pot   <= seq_pot + 2'h1;
               seq_state <= (seq_pot == seq_last) ? seq_idle : seq_read;
            end
            seq_save:
            begin
               seq_pot   <= seq_pot + 2'h1;
               seq_state <= (seq_pot == seq_last) ? seq_idle : seq_save;
            end
            default:
            begin
               seq_state <= seq_idle;
            end
         endcase
      end
   end

   // nonvolatile write timer
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         wip_timer <= '0;
      end
      else if (wip_start)
      begin
         wip_timer <= TIMER_BITS'(write_cycles);
      end
      else if (wip_timer != '0)
      begin
         wip_timer <= wip_timer - TIMER_BITS'(1);
      end
   end

   assign write_in_progress = wip_timer != '0;
endmodule

// file: quad_pot_monitor.sv
// Purpose: port checks for the quad pot serial decoder
// Assumes: bound to the decoder top module
// Notes:   write time measured by a helper counter
`timescale 1ns/1ps
module quad_pot_monitor
   import quad_pot_pkg::*;
#(
   parameter int write_cycles = WRITE_CYCLES
)
(
   input wire logic                              clock,
   input wire logic                              nrst,
   input wire logic                              cs_n,
   input wire logic                              sck,
   input wire logic                              si,
   input wire logic                              so,
   input wire logic                              so_en,
   input wire logic                              chip_addr_hi,
   input wire logic                              chip_addr_lo,
   input wire logic [POTS-1:0][WIPER_BITS-1:0]   wiper_position_reg,
   input wire logic                              write_in_progress
);
   logic [31:0]                     wip_cnt;
   logic [POTS-1:0][WIPER_BITS-1:0] prev_wiper;
   logic [2:0]                      moved;
   logic                            bad_step;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         wip_cnt <= '0;
      else
         wip_cnt <= write_in_progress ? wip_cnt + 32'h1 : '0;
   end

   always_ff @(posedge clock)
   begin
      prev_wiper <= wiper_position_reg;
   end

   // pots moved this cycle and whether any moved by more than one step
   always_comb
   begin
      moved    = '0;
      bad_step = 1'b0;
      for (int i = 0; i < POTS; i++)
      begin
         if (wiper_position_reg[i] != prev_wiper[i])
         begin
            moved    = moved + 3'h1;
            bad_step = bad_step | ((wiper_position_reg[i] - prev_wiper[i]) != 6'h01
                       && (prev_wiper[i] - wiper_position_reg[i]) != 6'h01);
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence frame_gap;
      cs_n [*2];
   endsequence

   sequence sck_fall_seen;
      sck ##1 !sck;
   endsequence

   a_so_en_idle: assert property (frame_gap |-> !so_en)
      else $error("output enable high between frames");
   a_so_en_start: assert property ($rose(so_en) |-> !cs_n && !sck)
      else $error("output enable rose outside a low serial clock phase");
   a_so_bit_timing: assert property (!cs_n && $past(!cs_n) && $changed(so)
      |-> $past(!sck) && $past(sck, 2))
      else $error("serial output changed away from a clock fall");
   a_step_timing: assert property (!cs_n && $past(!cs_n) && $past(!cs_n, 2)
      && $changed(wiper_position_reg) |-> $past(sck) && !$past(sck, 2))
      else $error("wiper moved in frame without a clock rise");
   a_step_size: assert property (!cs_n && $past(!cs_n) && $past(!cs_n, 2)
      && $changed(wiper_position_reg) |-> moved == 3'h1 && !bad_step)
      else $error("wiper step was not one segment on one pot");
   a_wip_after_cs: assert property ($rose(write_in_progress) |-> cs_n && $past(cs_n))
      else $error("write cycle started before chip select rose");
   a_wip_full_length: assert property ($fell(write_in_progress)
      |-> wip_cnt == write_cycles)
      else $error("write cycle length wrong");
   a_wip_upper_bound: assert property (write_in_progress |-> wip_cnt < write_cycles)
      else $error("write flag held too long");

   c_read_start: cover property (sck_fall_seen ##[1:2] $rose(so_en));
endmodule

bind quad_pot_spi_instruction_decoder quad_pot_monitor #(.write_cycles(write_cycles)) u_mon
   (.clock, .nrst, .cs_n, .sck, .si, .so, .so_en, .chip_addr_hi, .chip_addr_lo,
    .wiper_position_reg, .write_in_progress);

// file: host_master_model.sv
// Purpose: serial bus master that frames instructions for the decoder
// Assumes: driven at clock falls, four clocks per serial clock phase
// Notes:   data in is inverted after release so stale bits are not trusted
`timescale 1ns/1ps
module host_master_model
(
   input  wire logic clock,
   output logic      cs_n,
   output logic      sck,
   output logic      si,
   input  wire logic so
);
   initial
   begin
      cs_n = 1'b1;
      sck  = 1'b0;
      si   = 1'b0;
   end

   // sends nbits msb first, returns the last eight bits seen on so
   task automatic frame(input int nbits, input logic [31:0] bits_out,
                        output logic [7:0] rx);
      rx = '0;
      @(negedge clock);
      cs_n = 1'b0;
      for (int i = nbits - 1; i >= 0; i--)
      begin
         si = bits_out[i];
         repeat (4) @(negedge clock);
         rx  = {rx[6:0], so};
         sck = 1'b1;
         repeat (4) @(negedge clock);
         sck = 1'b0;
      end
      repeat (4) @(negedge clock);
      cs_n = 1'b1;
      si   = ~si;
      repeat (12) @(negedge clock);
   endtask
endmodule

// file: quad_pot_spi_instruction_decoder_tb.sv
// Purpose: self-checking bench for the quad pot serial decoder
// Assumes: strap address 2, shortened write time
// Notes:   table rows first, then transfer, save and step cases
`timescale 1ns/1ps
module quad_pot_spi_instruction_decoder_tb
   import quad_pot_pkg::*;
;
   localparam int         WC  = 400;
   localparam logic [7:0] HDR = {DEVICE_TYPE, ADDR_PAD, 2'h2};
   localparam logic [7:0] STS = {OP_STATUS, STATUS_SELECT};
   typedef struct packed {
      logic [7:0] instr;
      logic [7:0] data;
      logic [7:0] exp;
      logic       rd;
   } row_t;

   logic                            clock = 1'b0;
   logic                            nrst  = 1'b0;
   logic                            cs_n, sck, si, so, so_en, wip;
   logic [POTS-1:0][WIPER_BITS-1:0] wiper;
   logic [7:0]                      rx;
   int                              num_errors = 0;
   int                              num_checks = 0;
   row_t rows [10] = '{
      '{{OP_WR_WIPER, 4'h0}, 8'hd5, 8'h00, 1'b0}, '{{OP_WR_WIPER, 4'h1}, 8'h2a, 8'h00, 1'b0},
      '{{OP_WR_WIPER, 4'h2}, 8'h3f, 8'h00, 1'b0}, '{{OP_WR_WIPER, 4'h3}, 8'h41, 8'h00, 1'b0},
      '{{OP_RD_WIPER, 4'h0}, 8'h00, 8'h15, 1'b1}, '{{OP_RD_WIPER, 4'h1}, 8'h00, 8'h2a, 1'b1},
      '{{OP_RD_WIPER, 4'h2}, 8'h00, 8'h3f, 1'b1}, '{{OP_RD_WIPER, 4'h3}, 8'h00, 8'h01, 1'b1},
      '{STS, 8'h00, 8'h00, 1'b1}, '{{OP_RD_SETTING, 4'h5}, 8'h00, 8'h00, 1'b1}};

   // undriven output line reads as the inverse of the last bit
   wire                             so_line = so_en ? so : ~so;

   always #2.5 clock = ~clock;

   host_master_model host (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si), .so(so_line));

   quad_pot_spi_instruction_decoder #(.write_cycles(WC)) dut (
      .clock(clock), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
      .so_en(so_en), .chip_addr_hi(1'b1), .chip_addr_lo(1'b0),
      .wiper_position_reg(wiper), .write_in_progress(wip));

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_pots(input logic [POTS-1:0][WIPER_BITS-1:0] e);
      for (int i = 0; i < POTS; i++)
         check({2'b00, wiper[i]}, {2'b00, e[i]});
   endtask

   task automatic wait_idle();
      check({7'h0, wip}, 8'h01);
      host.frame(24, {8'h0, HDR, STS, 8'h00}, rx);
      check(rx, 8'h01);
      for (int n = 0; n < 20 && rx !== 8'h00; n++)
         host.frame(24, {8'h0, HDR, STS, 8'h00}, rx);
      check(rx, 8'h00);
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge clock);
      num_errors++;
      final_report();
   end

   initial
   begin
      repeat (12) @(negedge clock);
      nrst = 1'b1;
      repeat (2) @(negedge clock);
      check_pots('0);
      foreach (rows[i])
      begin
         host.frame(24, {8'h0, HDR, rows[i].instr, rows[i].data}, rx);
         if (rows[i].rd)
            check(rx, rows[i].exp);
      end
      host.frame(24, {8'h0, DEVICE_TYPE, ADDR_PAD, 2'h1, OP_WR_WIPER, 4'h0, 8'h00}, rx);
      check_pots({6'h01, 6'h3f, 6'h2a, 6'h15});
      host.frame(24, {8'h0, HDR, OP_WR_SETTING, 2'h2, 2'h1, 8'hec}, rx);
      // second write lands while the first is still busy and is dropped
      host.frame(24, {8'h0, HDR, OP_WR_SETTING, 2'h2, 2'h2, 8'h3f}, rx);
      wait_idle();
      host.frame(24, {8'h0, HDR, OP_RD_SETTING, 2'h2, 2'h1, 8'h00}, rx);
      check(rx, 8'h2c);
      host.frame(24, {8'h0, HDR, OP_RD_SETTING, 2'h2, 2'h2, 8'h00}, rx);
      check(rx, 8'h00);
      host.frame(16, {16'h0, HDR, OP_RECALL, 2'h2, 2'h1}, rx);
      check_pots({6'h01, 6'h3f, 6'h2c, 6'h15});
      host.frame(16, {16'h0, HDR, OP_SAVE, 2'h3, 2'h0}, rx);
      wait_idle();
      host.frame(24, {8'h0, HDR, OP_RD_SETTING, 2'h3, 2'h0, 8'h00}, rx);
      check(rx, 8'h15);
      host.frame(16, {16'h0, HDR, OP_G_SAVE, 2'h1, 2'h0}, rx);
      wait_idle();
      host.frame(16, {16'h0, HDR, OP_G_RECALL, 2'h0, 2'h0}, rx);
      check_pots('0);
      host.frame(16, {16'h0, HDR, OP_G_RECALL, 2'h1, 2'h0}, rx);
      check_pots({6'h01, 6'h3f, 6'h2c, 6'h15});
      // global recall with nonzero pot bits is ignored
      host.frame(16, {16'h0, HDR, OP_G_RECALL, 2'h0, 2'h1}, rx);
      check_pots({6'h01, 6'h3f, 6'h2c, 6'h15});
      host.frame(19, {13'h0, HDR, OP_INCDEC, 2'h0, 2'h2, 3'b100}, rx);
      host.frame(19, {13'h0, HDR, OP_INCDEC, 2'h0, 2'h3, 3'b001}, rx);
      check_pots({6'h01, 6'h3d, 6'h2c, 6'h15});
      nrst = 1'b0;
      repeat (3) @(negedge clock);
      check_pots('0);
      check({6'h0, so_en, wip}, 8'h00);
      nrst = 1'b1;
      repeat (3) @(negedge clock);
      final_report();
   end
endmodule
